// ===== tmz_pkg.sv
package tmz_pkg;

    // ************************************************************
    // Register map (byte addresses, one word each)
    // ************************************************************
    localparam logic [11:0] ADDR_COUNT   = 12'h000;
    localparam logic [11:0] ADDR_OPTION  = 12'h004;
    localparam logic [11:0] ADDR_INTCTL  = 12'h008;
    localparam logic [11:0] ADDR_STATUS  = 12'h00c;
    localparam logic [11:0] ADDR_MASK    = 12'h010;

    // ************************************************************
    // Option register fields
    // ************************************************************
    localparam int          OPT_CSS_BIT  = 5;
    localparam int          OPT_SES_BIT  = 4;
    localparam int          OPT_PAS_BIT  = 3;
    localparam int          OPT_PRF_LSB  = 0;
    localparam logic [7:0]  OPT_RESET    = 8'hff;

    // ************************************************************
    // Interrupt control register fields
    // ************************************************************
    localparam int          ICR_FLAG_BIT = 2;
    localparam int          ICR_EN_BIT   = 5;
    localparam logic [7:0]  ICR_RESET    = 8'h00;

    // ************************************************************
    // Status and mask layout
    // ************************************************************
    localparam int          STS_OVF_BIT  = 0;
    localparam int          STS_WDT_BIT  = 1;
    localparam logic [1:0]  STS_RESET    = 2'h0;
    localparam logic [1:0]  MASK_RESET   = 2'h0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int          INHIBIT_CYC  = 2;
    localparam int          SYNC_DELAY   = 2;

    // ************************************************************
    // Carried groups
    // ************************************************************
    typedef struct packed {
        logic       count_source_select;
        logic       source_edge_select;
        logic       prescaler_assign_select;
        logic [2:0] prescale_ratio_field;
    } tmz_option_t;

    typedef struct packed {
        logic       inst_cycle;
        logic       sleep;
        logic       watchdog_clear_instruction;
        logic       watchdog_tick;
    } tmz_core_t;

endpackage : tmz_pkg

// ===== tmz_prescaler.sv
module tmz_prescaler #(
    parameter int WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             tick,
    input  wire logic             clear,
    input  wire logic [2:0]       ratio,
    input  wire logic             to_wdt,
    output logic                  wrap
);
    import tmz_pkg::*;

    logic [WIDTH-1:0] cnt_ff;
    logic [WIDTH-1:0] nxt_cnt;
    logic [WIDTH-1:0] lim;

    initial begin
        if (WIDTH != 8) $error("prescaler must be 8 bits");
    end

    // Power of two divide: timer uses n+1, watchdog uses n
    function automatic logic [WIDTH-1:0] tmz_limit(input logic [2:0] n,
                                                   input logic w);
        logic [WIDTH:0] one_hot;
        one_hot = '0;
        one_hot[{1'b0, n} + {3'h0, ~w}] = 1'b1;
        return WIDTH'(one_hot - 1'b1);
    endfunction : tmz_limit

    always_comb begin
        lim     = tmz_limit(ratio, to_wdt); // RULE18
        nxt_cnt = cnt_ff;
        wrap    = 1'b0;
        if (clear) begin
            nxt_cnt = '0;
        end else if (tick) begin
            if (cnt_ff >= lim) begin
                nxt_cnt = '0;
                wrap    = 1'b1; // RULE19
            end else begin
                nxt_cnt = cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

endmodule : tmz_prescaler

// ===== tmz_timer0.sv
// What this block does
// RULE1: Read/write 8-bit counter, overflow at wrap
// RULE2: Clear source bit: count instruction cycles
// RULE3: Count write inhibits two instruction cycles
// RULE4: Set source bit: count external input edges
// RULE5: Edge bit: clear rising, set falling
// RULE6: External input synchronized before counting
// RULE7: One prescaler, timer or watchdog only
// RULE8: Prescaler count hidden, not loadable
// RULE9: Option low nibble: assign bit, ratio
// RULE10: Timer assignment divides 1:2 to 1:256
// RULE11: Watchdog assignment divides 1:1 to 1:128
// RULE12: Count write clears prescaler, keeps assignment
// RULE13: Watchdog clear also clears prescaler
// RULE14: Assignment may change while running
// RULE15: Software uses safe sequence when reassigning
// RULE16: Overflow sets flag; enable gates request
// RULE17: Timer halts in sleep, cannot wake
// RULE18: Ratio n: timer 2^(n+1), watchdog 2^n
// RULE19: Prescaled path counts prescaler wraps
//
// Added by the designer: the register offsets and register access over APB.
module tmz_timer0 (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  external_count_input,
    input  wire tmz_pkg::tmz_core_t    core,
    output logic                       overflow_irq,
    output logic                       watchdog_postscaled,
    output logic                       irq
);
    import tmz_pkg::*;

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic wr_acc;
    logic rd_acc;
    logic hit;
    assign wr_acc  = psel && penable && pwrite;
    assign rd_acc  = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign hit     = (paddr == ADDR_COUNT) || (paddr == ADDR_OPTION) ||
                     (paddr == ADDR_INTCTL) || (paddr == ADDR_STATUS) ||
                     (paddr == ADDR_MASK);
    assign pslverr = psel && penable && !hit;

    function automatic logic wr_to(input logic [11:0] a,
                                   input logic [11:0] r);
        return (a == r);
    endfunction : wr_to

    // ************************************************************
    // State
    // ************************************************************
    logic [7:0]  count_ff,  nxt_count;
    logic [7:0]  option_ff, nxt_option;
    logic [7:0]  icr_ff,    nxt_icr;
    logic [1:0]  sts_ff,    nxt_sts;
    logic [1:0]  mask_ff,   nxt_mask;
    logic [1:0]  inh_ff,    nxt_inh;
    logic [31:0] rdata_ff,  nxt_rdata;
    logic [2:0]  sync_ff,   nxt_sync;
    logic [SYNC_DELAY-1:0] dly_ff, nxt_dly;

    tmz_option_t opt;
    assign opt = '{count_source_select:     option_ff[OPT_CSS_BIT],
                   source_edge_select:      option_ff[OPT_SES_BIT],
                   prescaler_assign_select: option_ff[OPT_PAS_BIT],
                   prescale_ratio_field:    option_ff[OPT_PRF_LSB +: 3]};

    // ************************************************************
    // External input: three flops, edge where the two oldest differ
    // ************************************************************
    logic ext_edge;
    logic src_tick;
    logic count_wr;
    logic pre_tick;
    logic pre_clear;
    logic pre_wrap;
    logic inc;
    logic ovf;

    always_comb begin
        nxt_sync = {sync_ff[1:0], external_count_input}; // RULE6
        ext_edge = opt.source_edge_select ?
                   (sync_ff[2] && !sync_ff[1]) :
                   (!sync_ff[2] && sync_ff[1]); // RULE5
        // Edge pipeline gives the post-sync increment delay
        nxt_dly  = {dly_ff[SYNC_DELAY-2:0], ext_edge}; // RULE6
        src_tick = opt.count_source_select ?
                   dly_ff[SYNC_DELAY-1] : core.inst_cycle; // RULE2 RULE4
    end

    // ************************************************************
    // Shared prescaler
    // ************************************************************
    assign count_wr  = wr_acc && wr_to(paddr, ADDR_COUNT);
    // Sleep freezes the timer tick but not the watchdog feed
    assign pre_tick  = opt.prescaler_assign_select ? core.watchdog_tick :
                       (src_tick && !core.sleep); // RULE7 RULE17
    assign pre_clear = opt.prescaler_assign_select ?
                       core.watchdog_clear_instruction : // RULE13
                       count_wr; // RULE12

    tmz_prescaler #(.WIDTH(8)) u_pre ( // RULE8
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (pre_tick),
        .clear   (pre_clear),
        .ratio   (opt.prescale_ratio_field), // RULE9 RULE10 RULE11
        .to_wdt  (opt.prescaler_assign_select), // RULE14
        .wrap    (pre_wrap)
    );

    // ************************************************************
    // Counter, flag, registers
    // ************************************************************
    always_comb begin
        inc = 1'b0;
        if (!core.sleep && (inh_ff == 2'h0)) begin // RULE17
            inc = opt.prescaler_assign_select ? src_tick : pre_wrap; // RULE19
        end
        ovf        = inc && (count_wr == 1'b0) && (count_ff == 8'hff); // RULE1
        nxt_count  = inc ? count_ff + 8'h01 : count_ff;
        nxt_inh    = inh_ff;
        if (inh_ff != 2'h0 && core.inst_cycle) begin
            nxt_inh = inh_ff - 2'h1;
        end
        nxt_option = option_ff;
        nxt_icr    = icr_ff;
        nxt_mask   = mask_ff;
        nxt_sts    = sts_ff;
        if (count_wr) begin
            nxt_count = pwdata[7:0]; // RULE1
            nxt_inh   = 2'(INHIBIT_CYC); // RULE3
        end
        if (wr_acc && wr_to(paddr, ADDR_OPTION)) begin
            nxt_option = pwdata[7:0]; // RULE14
        end
        if (wr_acc && wr_to(paddr, ADDR_INTCTL)) begin
            nxt_icr = pwdata[7:0];
        end
        if (wr_acc && wr_to(paddr, ADDR_MASK)) begin
            nxt_mask = pwdata[1:0];
        end
        if (wr_acc && wr_to(paddr, ADDR_STATUS)) begin
            nxt_sts = sts_ff & ~pwdata[1:0];
        end
        // Hardware set wins over a same-cycle clear
        if (ovf) begin
            nxt_icr[ICR_FLAG_BIT] = 1'b1; // RULE16
            nxt_sts[STS_OVF_BIT]  = 1'b1;
        end
        if (pre_wrap && opt.prescaler_assign_select) begin
            nxt_sts[STS_WDT_BIT] = 1'b1;
        end
        nxt_rdata = rdata_ff;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                ADDR_COUNT:  nxt_rdata = {24'h0, count_ff};
                ADDR_OPTION: nxt_rdata = {24'h0, option_ff};
                ADDR_INTCTL: nxt_rdata = {24'h0, icr_ff};
                ADDR_STATUS: nxt_rdata = {30'h0, sts_ff};
                ADDR_MASK:   nxt_rdata = {30'h0, mask_ff};
                default:     nxt_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff  <= 8'h00;
            option_ff <= OPT_RESET;
            icr_ff    <= ICR_RESET;
            sts_ff    <= STS_RESET;
            mask_ff   <= MASK_RESET;
            inh_ff    <= 2'h0;
            rdata_ff  <= 32'h0;
            sync_ff   <= 3'h0;
            dly_ff    <= '0;
        end else begin
            count_ff  <= nxt_count;
            option_ff <= nxt_option;
            icr_ff    <= nxt_icr;
            sts_ff    <= nxt_sts;
            mask_ff   <= nxt_mask;
            inh_ff    <= nxt_inh;
            rdata_ff  <= nxt_rdata;
            sync_ff   <= nxt_sync;
            dly_ff    <= nxt_dly;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata              = rdata_ff;
    assign overflow_irq        = icr_ff[ICR_FLAG_BIT] &&
                                 icr_ff[ICR_EN_BIT]; // RULE16
    assign watchdog_postscaled = opt.prescaler_assign_select ? pre_wrap :
                                 core.watchdog_tick; // RULE11
    assign irq                 = |(sts_ff & mask_ff);

endmodule : tmz_timer0

// ===== tmz_timer0_monitor.sv
module tmz_mon (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic               pwrite,
    input wire logic [11:0]        paddr,
    input wire logic [31:0]        pwdata,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire tmz_pkg::tmz_core_t core,
    input wire logic               overflow_irq,
    input wire logic               irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import tmz_pkg::*;
    // ****************************************
    // Shadow of enable and mask bits
    // ****************************************
    logic       en_ff;
    logic       nxt_en;
    logic [1:0] msk_ff;
    logic [1:0] nxt_msk;
    wire        acc = psel && penable;
    wire        wr  = acc && pwrite;
    always_comb begin
        nxt_en = en_ff;
        nxt_msk = msk_ff;
        if (wr && paddr == ADDR_INTCTL) nxt_en = pwdata[ICR_EN_BIT];
        if (wr && paddr == ADDR_MASK) nxt_msk = pwdata[1:0];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff <= 1'b0;
            msk_ff <= MASK_RESET;
        end else begin
            en_ff <= nxt_en;
            msk_ff <= nxt_msk;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_high: assert property (acc |-> pready)
        else $error("access without ready");
    a_err_unmapped: assert property (acc && paddr > ADDR_MASK |-> pslverr)
        else $error("no error on unmapped address");
    a_err_mapped: assert property (acc && paddr <= ADDR_MASK
        && paddr[1:0] == 2'h0 |-> !pslverr) else $error("error on mapped");
    a_read_zero: assert property (acc && !pwrite && paddr > ADDR_MASK
        |-> prdata == 32'h0) else $error("unmapped read not zero");
    a_rdata_hold: assert property (!(psel && !penable && !pwrite)
        |=> $stable(prdata)) else $error("read data moved");
    a_ovf_gated: assert property (overflow_irq |-> en_ff)
        else $error("overflow request while disabled");
    a_irq_masked: assert property (irq |-> msk_ff != 2'h0)
        else $error("irq with all masked");
    // Sleep gates the increment in the same cycle; one cycle would do, four is margin
    a_sleep_quiet: assert property ($rose(overflow_irq)
        && $past(core.sleep) && $past(core.sleep, 2) && $past(core.sleep, 3)
        && $past(core.sleep, 4) |-> $past(wr)) else $error("count in sleep");
endmodule : tmz_mon

// ===== tmz_timer0_test.sv
module tmz_timer0_test;
    timeunit 1ns;
    timeprecision 1ns;
    import tmz_pkg::*;
    // ****************************************
    // Bench
    // ****************************************
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, ext = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, v;
    logic        pready, pslverr, ovf_irq, wpost, irq, err;
    tmz_core_t   core = '0;
    int          num_errors = 0, n_compared = 0, wcnt = 0, n;
    logic [7:0]  lf = 8'h12;
    always #25 pclk = ~pclk;
    always @(posedge pclk) if (wpost === 1'b1) wcnt++;
    tmz_timer0 dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .external_count_input(ext), .core(core), .overflow_irq(ovf_irq),
        .watchdog_postscaled(wpost), .irq(irq));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task complete_run;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : complete_run
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Pins are settled two falling edges after release
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) num_errors++;
        if (i == 16) complete_run();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(negedge pclk);
    endtask : apb
    task rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rchk
    task pulse(input int s, input int k);
        repeat (k) begin
            @(posedge pclk);
            if (s == 0) core.inst_cycle <= 1'b1;
            else if (s == 1) core.watchdog_tick <= 1'b1;
            else core.watchdog_clear_instruction <= 1'b1;
            @(posedge pclk);
            // Sleep is a level and must survive the pulse
            core.inst_cycle                 <= 1'b0;
            core.watchdog_tick              <= 1'b0;
            core.watchdog_clear_instruction <= 1'b0;
            @(posedge pclk);
        end
    endtask : pulse
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rchk(ADDR_COUNT, 32'h0);
        rchk(ADDR_OPTION, {24'h0, OPT_RESET});
        rchk(12'h020, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, ADDR_OPTION, 32'h08);
        lf = lfsr(lf);
        v = {28'hf, lf[3:0]};
        apb(1'b1, ADDR_COUNT, v);
        pulse(0, 18);
        rchk(ADDR_COUNT, (v + 32'd16) & 32'hff);
        rchk(ADDR_INTCTL, 32'h04);
        rchk(ADDR_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_INTCTL, 32'h24);
        chk({31'h0, ovf_irq}, 32'h1);
        apb(1'b1, ADDR_INTCTL, 32'h04);
        chk({31'h0, ovf_irq}, 32'h0);
        apb(1'b1, ADDR_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        core.sleep <= 1'b1;
        apb(1'b1, ADDR_COUNT, 32'h33);
        pulse(0, 6);
        rchk(ADDR_COUNT, 32'h33);
        core.sleep <= 1'b0;
        for (n = 0; n < 8; n++) begin
            apb(1'b1, ADDR_OPTION, 32'(n));
            apb(1'b1, ADDR_COUNT, 32'h0);
            pulse(0, 2 + (2 << n));
            apb(1'b0, ADDR_COUNT, 32'h0);
            v = rd;
            pulse(0, 3 * (2 << n));
            rchk(ADDR_COUNT, v + 32'd3);
        end
        for (n = 0; n < 8; n++) begin
            pulse(2, 1);
            apb(1'b1, ADDR_OPTION, 32'(8 | n));
            lf = lfsr(lf);
            pulse(1, int'(lf[2:0]));
            pulse(2, 1);
            @(negedge pclk);
            wcnt = 0;
            pulse(1, (2 << n) - 1);
            repeat (2) @(negedge pclk);
            chk(wcnt, 32'd1);
            rchk(ADDR_STATUS, 32'h2);
        end
        for (n = 0; n < 2; n++) begin
            ext <= 1'b0;
            apb(1'b1, ADDR_OPTION, 32'(8'h28 | (n << 4)));
            apb(1'b1, ADDR_COUNT, 32'h0);
            pulse(0, 3);
            repeat (5) begin
                @(posedge pclk);
                ext <= ~ext;
                repeat (8) @(posedge pclk);
            end
            rchk(ADDR_COUNT, 32'(3 - n));
        end
        complete_run();
    end
endmodule : tmz_timer0_test
bind tmz_timer0 tmz_mon mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .core(core),
    .overflow_irq(overflow_irq), .irq(irq));
